/* common/timer_types_pkg.sv */
// types shared by the timer core and its channel slices
// assumes nothing beyond a SystemVerilog compiler
package timer_types_pkg;

   // how a channel counter steps on each count tick
   typedef enum logic [1:0] {CNT_UP, CNT_PHASE, CNT_TURN} count_mode_t;

   // operating mode of the channel 3/4 pair
   typedef enum logic [1:0] {PAIR_NONE, PAIR_COMPL, PAIR_RSYNC} pair_mode_t;

endpackage

/* common/timer_map.svh */
// register offsets, field positions and reset values of the timer core
// assumes byte addresses on the internal 16-bit bus
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// global registers (byte addresses)
`define OFS_START    8'h00
`define OFS_MODE     8'h02
`define OFS_FUNC     8'h04
`define OFS_MEN      8'h06
`define OFS_OUTCTL   8'h08

// per channel: block at 8'h10*(ch+1), register at low nibble
`define OFS_CTRL     4'h0
`define OFS_IOC      4'h2
`define OFS_STAT     4'h4
`define OFS_CNT      4'h6
`define OFS_GRA      4'h8
`define OFS_GRB      4'hA

// output control fields
`define EXTERNAL_TRIGGER_DISABLE_BIT     4
`define OLS_HI_BIT   1
`define OLS_LO_BIT   0
`define OUTCTL_FIXED 8'hEC
`define RST_OUTCTL   8'hFF

// master enable fields
`define ME_CH3A      0
`define ME_CH4A      1
`define ME_CH4B      2
`define ME_CH3B      3
`define ME_ALTA      4
`define ME_ALTB      5
`define MEN_FIXED    8'hC0
`define RST_MEN      6'h3F

// mode register phase-counting bit, status flag positions
`define PHASE_BIT    6
`define FLAG_A       0
`define FLAG_B       1
`define FLAG_OVF     2

// counter and general register reset values
`define RST_CNT      16'h0000
`define RST_GR       16'hFFFF

`endif

/* hw/timer_channel.sv */
// one timer channel: counter, two general registers, flags, pin levels
// assumes synchronised capture levels and a one-cycle count tick
`timescale 1ns/10ps
`include "timer_map.svh"
module timer_channel
   import timer_types_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          init,
   input  wire logic          tick,
   input  wire logic          dir_up,
   input  wire count_mode_t   cmode,
   input  wire logic          pwm,
   input  wire logic [1:0]    clr_sel,
   input  wire logic [2:0]    ioc_a,
   input  wire logic [2:0]    ioc_b,
   input  wire logic          cap_in_a,
   input  wire logic          cap_in_b,
   input  wire logic          wr_cnt,
   input  wire logic          wr_gra,
   input  wire logic          wr_grb,
   input  wire logic          wr_stat,
   input  wire logic [1:0]    be,
   input  wire logic [W-1:0]  wdata,
   output logic      [W-1:0]  cnt,
   output logic      [W-1:0]  general_reg_a,
   output logic      [W-1:0]  general_reg_b,
   output logic      [2:0]    flags,
   output logic               cap_a_evt,
   output logic               lvl_a,
   output logic               lvl_b
);

   logic [W-1:0] cnt_reg, cnt_next, gra_reg, gra_next, grb_reg, grb_next;
   logic [2:0]   flags_reg, flags_next;
   logic         ina_reg, ina_next, inb_reg, inb_next;
   logic         dir_reg, dir_next, lva_reg, lva_next, lvb_reg, lvb_next;
   logic         cap_a, cap_b, match_a, match_b, up, ovf, clr;

   // byte lanes: be[1] high byte, be[0] low byte
   function automatic logic [W-1:0] merge(input logic [W-1:0] old,
                                          input logic [1:0]   en,
                                          input logic [W-1:0] wd);
      merge = {en[1] ? wd[W-1:8] : old[W-1:8], en[0] ? wd[7:0] : old[7:0]};
   endfunction

   // edge code: 00 rising, 01 falling, 1x both
   function automatic logic edge_hit(input logic p, input logic c,
                                     input logic [1:0] sel);
      edge_hit = sel[1] ? (p ^ c) : (sel[0] ? (p & ~c) : (~p & c));
   endfunction

   // compare output code: 00 hold, 01 low, 10 high, 11 toggle
   function automatic logic out_lvl(input logic cur, input logic [1:0] code);
      out_lvl = (code == 2'b11) ? ~cur : ((code == 2'b00) ? cur : code[1]);
   endfunction

   // event decode; io control is ignored in any pwm mode
   always_comb begin
      cap_a   = !pwm && ioc_a[2] && edge_hit(ina_reg, cap_in_a, ioc_a[1:0]);
      cap_b   = !pwm && ioc_b[2] && edge_hit(inb_reg, cap_in_b, ioc_b[1:0]);
      match_a = tick && (pwm || !ioc_a[2]) && (cnt_reg == gra_reg);
      match_b = tick && (pwm || !ioc_b[2]) && (cnt_reg == grb_reg);
      clr     = (clr_sel == 2'b01 && (match_a || cap_a)) ||
                (clr_sel == 2'b10 && (match_b || cap_b));
      up      = (cmode == CNT_UP) ? 1'b1 :
                ((cmode == CNT_PHASE) ? dir_up : dir_reg);
      ovf     = tick && ((up && (&cnt_reg)) ||
                (!up && cnt_reg == `RST_CNT));
   end

   // next state of counter, registers, flags and levels
   always_comb begin
      cnt_next   = cnt_reg;
      gra_next   = gra_reg;
      grb_next   = grb_reg;
      flags_next = flags_reg;
      dir_next   = dir_reg;
      lva_next   = lva_reg;
      lvb_next   = lvb_reg;
      ina_next   = cap_in_a;
      inb_next   = cap_in_b;
      // bus write beats clearing, clearing beats counting
      if (wr_cnt)
         cnt_next = merge(cnt_reg, be, wdata);
      else if (clr)
         cnt_next = `RST_CNT;
      else if (tick) begin
         if (cmode == CNT_TURN && !up && cnt_reg == `RST_CNT) begin
            cnt_next = W'(1); // turning point counts as underflow
            dir_next = 1'b1;
         end else
            cnt_next = up ? W'(cnt_reg + 1'b1) : W'(cnt_reg - 1'b1);
         if (cmode == CNT_TURN && up && cnt_reg == gra_reg)
            dir_next = 1'b0;
      end
      if (cmode != CNT_TURN)
         dir_next = 1'b1;
      // a capture wins over a bus write in the same cycle
      if (cap_a)
         gra_next = cnt_reg;
      else if (wr_gra)
         gra_next = merge(gra_reg, be, wdata);
      if (cap_b)
         grb_next = cnt_reg;
      else if (wr_grb)
         grb_next = merge(grb_reg, be, wdata);
      // write 0 clears a flag; a set in the same cycle wins
      if (wr_stat && be[0])
         flags_next = flags_reg & wdata[2:0];
      flags_next[`FLAG_A]   = flags_next[`FLAG_A] | match_a | cap_a;
      flags_next[`FLAG_B]   = flags_next[`FLAG_B] | match_b | cap_b;
      flags_next[`FLAG_OVF] = flags_next[`FLAG_OVF] | ovf;
      // pin levels: pwm sets A at A, clears A and toggles B at B; else per io code
      if (pwm) begin
         if (match_a) lva_next = 1'b1;
         if (match_b) lva_next = 1'b0;
         if (match_b) lvb_next = ~lvb_reg;
      end else begin
         if (match_a) lva_next = out_lvl(lva_reg, ioc_a[1:0]);
         if (match_b) lvb_next = out_lvl(lvb_reg, ioc_b[1:0]);
      end
      // standby puts counter, registers, flags, direction and levels back to reset state
      if (init) begin
         cnt_next   = `RST_CNT;
         gra_next   = `RST_GR;
         grb_next   = `RST_GR;
         flags_next = 3'h0;
         dir_next   = 1'b1;
         lva_next   = 1'b0;
         lvb_next   = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg   <= `RST_CNT;
         gra_reg   <= `RST_GR;
         grb_reg   <= `RST_GR;
         flags_reg <= 3'h0;
         dir_reg   <= 1'b1;
         lva_reg   <= 1'b0;
         lvb_reg   <= 1'b0;
         ina_reg   <= 1'b0;
         inb_reg   <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         gra_reg   <= gra_next;
         grb_reg   <= grb_next;
         flags_reg <= flags_next;
         dir_reg   <= dir_next;
         lva_reg   <= lva_next;
         lvb_reg   <= lvb_next;
         ina_reg   <= ina_next;
         inb_reg   <= inb_next;
      end
   end

   assign cnt       = cnt_reg;
   assign general_reg_a       = gra_reg;
   assign general_reg_b       = grb_reg;
   assign flags     = flags_reg;
   assign cap_a_evt = cap_a;
   assign lvl_a     = lva_reg;
   assign lvl_b     = lvb_reg;

endmodule

/* hw/timer_core.sv */
// five-channel 16-bit timer core behind the internal 16-bit cpu bus
// assumes a single-cycle write strobe and reads answered one cycle later
//
// Functional notes
// - master enable bit 0 low: channel 3 pin A never driven by timer
// - trigger enabled: channel 1 capture A clears channel 3 A enable
// - master enable bit 0 high: pin A follows io, mode, function settings
// - output control resets to all ones on reset and standby
// - output control bits 7-5, 3, 2 ignore writes and read as one
// - trigger disable and level selects act only in paired pwm modes
// - bit 4 low: channel 1 capture A clears master enables 5 to 0
// - level select high bit low inverts ch3 A, ch4 A, ch4 B outputs
// - level select low bit low inverts ch3 B and both channel-4 alternates
// - each channel counts ticks from its prescaler-selected clock source; ch2 in phase mode counts ext clock A edges
// - ch0/1 up only; ch2 up/down in phase mode; ch3/4 in complementary
// - counter clears on match or capture of its A or B register
// - wrap from all ones to zero sets the channel overflow flag
// - wrap from zero to all ones counting down sets overflow too
// - counters read and written by word or byte over the bus
// - counters reset to zero on reset and standby
// - two general registers per channel, compare or capture by io control
// - compare: equality with counter sets the matching A or B flag
// - capture: selected edge copies counter and sets the flag together
// - io control ignored in pwm, complementary and reset-synchronized pwm
// - general registers read and written by word or byte over the bus
// - general registers reset to all ones, compare with no output
// - pair select bits join ch3/4; low bit picks complementary or reset-sync
`timescale 1ns/10ps
`include "timer_map.svh"
module timer_core
   import timer_types_pkg::*;
#(
   parameter int NCH = 5
)(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        STANDBY,
   input  wire logic [7:0]  BUS_ADDR,
   input  wire logic        BUS_WR,
   input  wire logic        BUS_RD,
   input  wire logic [1:0]  BUS_BE,
   input  wire logic [15:0] BUS_WDATA,
   output logic      [15:0] BUS_RDATA,
   output logic             BUS_RVALID,
   input  wire logic [3:0]  EXT_CLK_IN,
   input  wire logic [4:0]  PIN_A_IN,
   input  wire logic [4:0]  PIN_B_IN,
   output logic      [4:0]  PIN_A_OUT,
   output logic      [4:0]  PIN_A_OE_N,
   output logic      [4:0]  PIN_B_OUT,
   output logic      [4:0]  PIN_B_OE_N,
   output logic      [1:0]  ALT_OUT,
   output logic      [1:0]  ALT_OE_N
);

   localparam int NSYNC = 4 + 2 * NCH;

   // pin synchroniser: three stages, level changes when stage 2 and 3 agree
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg;
   logic [NSYNC-1:0] filt_reg, filt_next, filtq_reg;
   logic [3:0]       ext_f, ext_q, ext_rise;

   assign pin_raw = {PIN_B_IN, PIN_A_IN, EXT_CLK_IN};

   always_comb begin
      filt_next = (~(s2_reg ^ s3_reg) & s3_reg) |
                  ((s2_reg ^ s3_reg) & filt_reg);
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         filt_reg  <= '0;
         filtq_reg <= '0;
      end else begin
         s1_reg    <= pin_raw;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         filt_reg  <= filt_next;
         filtq_reg <= filt_reg;
      end
   end

   assign ext_f    = filt_reg[3:0];
   assign ext_q    = filtq_reg[3:0];
   assign ext_rise = ext_f & ~ext_q;

   // control and configuration registers
   logic [4:0]  start_reg, start_next;
   logic [7:0]  mode_reg, mode_next;
   logic [1:0]  func_reg, func_next;
   logic [5:0]  men_reg, men_next;
   logic        external_trigger_disable_reg, external_trigger_disable_next;
   logic        olsh_reg, olsh_next;
   logic        olsl_reg, olsl_next;
   logic [7:0]  ctrl_reg [NCH];
   logic [7:0]  ctrl_next [NCH];
   logic [7:0]  ioc_reg [NCH];
   logic [7:0]  ioc_next [NCH];
   logic [2:0]  div_reg, div_next;
   logic [15:0] rdata_reg, rdata_next;
   logic        rvalid_reg;

   // channel outputs
   logic [15:0] cnt_w [NCH];
   logic [15:0] gra_w [NCH];
   logic [15:0] grb_w [NCH];
   logic [2:0]  flags_w [NCH];
   logic [NCH-1:0] cap_a_w, lvl_a_w, lvl_b_w, pwm_w;

   // bus address split
   logic [3:0]  ch_sel;
   logic [2:0]  ch_idx;
   logic        ch_hit;
   pair_mode_t  pair;
   logic        paired, trigger, inv_hi, inv_lo;

   assign ch_sel = BUS_ADDR[7:4];
   assign ch_idx = 3'(ch_sel - 4'h1);
   assign ch_hit = (ch_sel >= 4'h1) && (ch_sel <= 4'(NCH));

   // pair select: 1x joins ch3/4, low bit picks reset-synchronized
   always_comb begin
      if (!func_reg[1])
         pair = PAIR_NONE;
      else if (func_reg[0])
         pair = PAIR_RSYNC;
      else
         pair = PAIR_COMPL;
   end

   assign paired  = (pair != PAIR_NONE);
   // external trigger only counts in the paired modes
   assign trigger = paired && !external_trigger_disable_reg && cap_a_w[1];
   assign inv_hi  = paired && !olsh_reg;
   assign inv_lo  = paired && !olsl_reg;

   // register writes; standby and the trigger override the bus
   always_comb begin
      start_next = start_reg;
      mode_next  = mode_reg;
      func_next  = func_reg;
      men_next   = men_reg;
      external_trigger_disable_next  = external_trigger_disable_reg;
      olsh_next  = olsh_reg;
      olsl_next  = olsl_reg;
      ctrl_next  = ctrl_reg;
      ioc_next   = ioc_reg;
      div_next   = 3'(div_reg + 3'h1);
      if (BUS_WR && BUS_BE[0]) begin
         if (BUS_ADDR == `OFS_START)
            start_next = BUS_WDATA[4:0];
         else if (BUS_ADDR == `OFS_MODE)
            mode_next = BUS_WDATA[7:0];
         else if (BUS_ADDR == `OFS_FUNC)
            func_next = BUS_WDATA[1:0];
         else if (BUS_ADDR == `OFS_MEN)
            men_next = BUS_WDATA[5:0];
         else if (BUS_ADDR == `OFS_OUTCTL) begin
            // fixed bits are not stored at all
            external_trigger_disable_next = BUS_WDATA[`EXTERNAL_TRIGGER_DISABLE_BIT];
            olsh_next = BUS_WDATA[`OLS_HI_BIT];
            olsl_next = BUS_WDATA[`OLS_LO_BIT];
         end else if (ch_hit && BUS_ADDR[3:0] == `OFS_CTRL)
            ctrl_next[ch_idx] = BUS_WDATA[7:0];
         else if (ch_hit && BUS_ADDR[3:0] == `OFS_IOC)
            ioc_next[ch_idx] = BUS_WDATA[7:0];
      end
      // same edge as the capture, so no extra cycle of drive
      if (trigger)
         men_next = 6'h00;
      if (STANDBY) begin
         start_next = 5'h00;
         mode_next  = 8'h00;
         func_next  = 2'h0;
         men_next   = `RST_MEN;
         external_trigger_disable_next  = 1'b1;
         olsh_next  = 1'b1;
         olsl_next  = 1'b1;
         div_next   = 3'h0;
         for (int i = 0; i < NCH; i++) begin
            ctrl_next[i] = 8'h00;
            ioc_next[i]  = 8'h00;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         start_reg <= 5'h00;
         mode_reg  <= 8'h00;
         func_reg  <= 2'h0;
         men_reg   <= `RST_MEN;
         external_trigger_disable_reg  <= 1'b1;
         olsh_reg  <= 1'b1;
         olsl_reg  <= 1'b1;
         div_reg   <= 3'h0;
         for (int i = 0; i < NCH; i++) begin
            ctrl_reg[i] <= 8'h00;
            ioc_reg[i]  <= 8'h00;
         end
      end else begin
         start_reg <= start_next;
         mode_reg  <= mode_next;
         func_reg  <= func_next;
         men_reg   <= men_next;
         external_trigger_disable_reg  <= external_trigger_disable_next;
         olsh_reg  <= olsh_next;
         olsl_reg  <= olsl_next;
         div_reg   <= div_next;
         ctrl_reg  <= ctrl_next;
         ioc_reg   <= ioc_next;
      end
   end

   // prescaler tick: internal /1,/2,/4,/8 or rising edge of an ext clock
   function automatic logic tick_sel(input logic [2:0] sel,
                                     input logic [2:0] div,
                                     input logic [3:0] rise);
      case (sel)
         3'h0:    tick_sel = 1'b1;
         3'h1:    tick_sel = div[0];
         3'h2:    tick_sel = &div[1:0];
         3'h3:    tick_sel = &div;
         default: tick_sel = rise[sel[1:0]];
      endcase
   endfunction

   // one slice per channel; ch2 may phase count, ch3/4 join when paired
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic        hit, phase_on, tick, pwm;
      count_mode_t cmode;

      assign hit      = BUS_WR && ch_sel == 4'(i + 1);
      assign phase_on = mode_reg[`PHASE_BIT] && (i == 2);
      // phase counting steps on every edge of ext clock A
      assign tick     = start_reg[i] && (phase_on ? (ext_f[0] ^ ext_q[0]) :
                        tick_sel(ctrl_reg[i][2:0], div_reg, ext_rise));
      assign cmode    = phase_on ? CNT_PHASE :
                        ((pair == PAIR_COMPL && i >= 3) ? CNT_TURN : CNT_UP);
      assign pwm      = mode_reg[i] || (paired && i >= 3);
      assign pwm_w[i] = pwm;

      timer_channel #(
         .W (16)
      ) u_ch (
         .clk       (SYS_CLK),
         .rst       (RST),
         .init      (STANDBY),
         .tick      (tick),
         .dir_up    (ext_f[0] ^ ext_f[1]),
         .cmode     (cmode),
         .pwm       (pwm),
         .clr_sel   (ctrl_reg[i][6:5]),
         .ioc_a     (ioc_reg[i][2:0]),
         .ioc_b     (ioc_reg[i][6:4]),
         .cap_in_a  (filt_reg[4 + i]),
         .cap_in_b  (filt_reg[4 + NCH + i]),
         .wr_cnt    (hit && BUS_ADDR[3:0] == `OFS_CNT),
         .wr_gra    (hit && BUS_ADDR[3:0] == `OFS_GRA),
         .wr_grb    (hit && BUS_ADDR[3:0] == `OFS_GRB),
         .wr_stat   (hit && BUS_ADDR[3:0] == `OFS_STAT),
         .be        (BUS_BE),
         .wdata     (BUS_WDATA),
         .cnt       (cnt_w[i]),
         .general_reg_a       (gra_w[i]),
         .general_reg_b       (grb_w[i]),
         .flags     (flags_w[i]),
         .cap_a_evt (cap_a_w[i]),
         .lvl_a     (lvl_a_w[i]),
         .lvl_b     (lvl_b_w[i])
      );
   end

   // read decode; unmapped addresses read zero
   always_comb begin
      rdata_next = 16'h0000;
      if (BUS_ADDR == `OFS_START)
         rdata_next = {11'h000, start_reg};
      else if (BUS_ADDR == `OFS_MODE)
         rdata_next = {8'h00, mode_reg};
      else if (BUS_ADDR == `OFS_FUNC)
         rdata_next = {14'h0, func_reg};
      else if (BUS_ADDR == `OFS_MEN)
         rdata_next = {8'h00, `MEN_FIXED | {2'b00, men_reg}};
      else if (BUS_ADDR == `OFS_OUTCTL)
         rdata_next = {8'h00, `OUTCTL_FIXED |
                       {3'b000, external_trigger_disable_reg, 2'b00, olsh_reg, olsl_reg}};
      else if (ch_hit) begin
         if (BUS_ADDR[3:0] == `OFS_CTRL)
            rdata_next = {8'h00, ctrl_reg[ch_idx]};
         else if (BUS_ADDR[3:0] == `OFS_IOC)
            rdata_next = {8'h00, ioc_reg[ch_idx]};
         else if (BUS_ADDR[3:0] == `OFS_STAT)
            rdata_next = {13'h0, flags_w[ch_idx]};
         else if (BUS_ADDR[3:0] == `OFS_CNT)
            rdata_next = cnt_w[ch_idx];
         else if (BUS_ADDR[3:0] == `OFS_GRA)
            rdata_next = gra_w[ch_idx];
         else if (BUS_ADDR[3:0] == `OFS_GRB)
            rdata_next = grb_w[ch_idx];
      end
   end

   // read data holds until the next read
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= BUS_RD ? rdata_next : rdata_reg;
         rvalid_reg <= BUS_RD;
      end
   end

   assign BUS_RDATA  = rdata_reg;
   assign BUS_RVALID = rvalid_reg;

   // pin drive: gating, plus ch3/4 levels inverted by level selects in paired modes
   logic [4:0] a_out, a_drv, b_out, b_drv;
   logic [1:0] alt_out, alt_drv;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         a_out[i] = lvl_a_w[i];
         b_out[i] = lvl_b_w[i];
         // compare code 00 means no pin output
         a_drv[i] = pwm_w[i] ||
                    (!ioc_reg[i][2] && ioc_reg[i][1:0] != 2'b00);
         b_drv[i] = !pwm_w[i] &&
                    !ioc_reg[i][6] && ioc_reg[i][5:4] != 2'b00;
      end
      alt_out = 2'b00;
      alt_drv = 2'b00;
      if (paired) begin
         a_out[3] = lvl_a_w[3] ^ inv_hi;
         b_out[3] = ~lvl_a_w[3] ^ inv_lo;
         a_out[4] = lvl_a_w[4] ^ inv_hi;
         b_out[4] = lvl_b_w[4] ^ inv_hi;
         alt_out  = {~lvl_b_w[4] ^ inv_lo, ~lvl_a_w[4] ^ inv_lo};
         b_drv[3] = 1'b1;
         b_drv[4] = 1'b1;
         alt_drv  = 2'b11;
      end
      // master enables override every other setting
      a_drv[3] = a_drv[3] && men_reg[`ME_CH3A];
      b_drv[3] = b_drv[3] && men_reg[`ME_CH3B];
      a_drv[4] = a_drv[4] && men_reg[`ME_CH4A];
      b_drv[4] = b_drv[4] && men_reg[`ME_CH4B];
      alt_drv  = alt_drv & {men_reg[`ME_ALTB], men_reg[`ME_ALTA]};
   end

   assign PIN_A_OUT  = a_out;
   assign PIN_A_OE_N = ~a_drv;
   assign PIN_B_OUT  = b_out;
   assign PIN_B_OE_N = ~b_drv;
   assign ALT_OUT    = alt_out;
   assign ALT_OE_N   = ~alt_drv;

endmodule

/* tb/timer_core_properties.sv */
// checker on the timer core ports
// assumes one clock domain, bound below
`timescale 1ns/10ps
module timer_core_chk (
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        STANDBY,
   input wire logic [7:0]  BUS_ADDR,
   input wire logic        BUS_WR,
   input wire logic        BUS_RD,
   input wire logic [15:0] BUS_RDATA,
   input wire logic        BUS_RVALID,
   input wire logic [4:0]  PIN_A_OE_N,
   input wire logic [4:0]  PIN_B_OE_N,
   input wire logic [1:0]  ALT_OE_N
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // standby pulse, then a lone read two edges on
   sequence s_sb_rd(a);
      STANDBY ##2 (BUS_RD && !BUS_WR && BUS_ADDR == a);
   endsequence
   a_read_answered: assert property (BUS_RD |=> BUS_RVALID)
      else $error("read not answered");
   a_answer_cause: assert property (BUS_RVALID |-> $past(BUS_RD))
      else $error("stray read answer");
   a_rdata_holds: assert property (!BUS_RVALID |->
      $stable(BUS_RDATA)) else $error("read data moved");
   a_outctl_fixed: assert property (BUS_RD && BUS_ADDR == 8'h08
      |=> (BUS_RDATA & 16'hFFEC) == 16'h00EC) else $error("fixed bits");
   a_sb_outctl: assert property (s_sb_rd(8'h08) |=>
      BUS_RDATA == 16'h00FF) else $error("output control init");
   a_sb_counter: assert property (s_sb_rd(8'h16) |=>
      BUS_RDATA == 16'h0000) else $error("counter init");
   a_sb_general: assert property (s_sb_rd(8'h18) |=>
      BUS_RDATA == 16'hFFFF) else $error("general reg init");
   a_sb_no_drive: assert property (STANDBY |=>
      &PIN_A_OE_N && &PIN_B_OE_N && &ALT_OE_N) else $error("pin driven");
   a_master_off: assert property (BUS_RVALID &&
      $past(BUS_ADDR) == 8'h06 &&
      !$past(BUS_WR) && !$past(STANDBY) && !BUS_RDATA[0]
      |-> PIN_A_OE_N[3]) else $error("disabled pin driven");
endmodule
bind timer_core timer_core_chk i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .STANDBY(STANDBY), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
   .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .PIN_A_OE_N(PIN_A_OE_N),
   .PIN_B_OE_N(PIN_B_OE_N), .ALT_OE_N(ALT_OE_N));

/* tb/cpu_bus_model.sv */
// cpu side of the internal 16-bit register bus
// assumes reads are answered one cycle after the strobe
`timescale 1ns/10ps
module cpu_bus_model (
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   input  wire logic        rvalid,
   output logic      [7:0]  addr = 8'h00,
   output logic             wr = 1'b0,
   output logic             rd = 1'b0,
   output logic      [1:0]  be = 2'h0,
   output logic      [15:0] wdata = 16'h0000
);
   // one-edge write; byte lanes per be
   task automatic wr16(input logic [7:0] a, input logic [1:0] b,
                       input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      be <= b;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d; // stale data must not look valid
   endtask
   // answer taken at the edge after the taking edge
   task automatic rd16(input logic [7:0] a, output logic [15:0] d,
                       output logic ok);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
      ok = rvalid;
   endtask
endmodule

/* tb/timer_core_tb_top.sv */
// self-checking bench for the timer core registers
// assumes the bus model and the bound checker
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
module timer_core_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sb = 1'b0;
   logic [4:0]  pin = 5'h00;
   logic [7:0]  addr;
   logic        wr, rd, rv;
   logic [1:0]  be;
   logic [15:0] wd, rdat;
   logic [4:0]  pa, pb;
   logic [1:0]  alt;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;
   always #5 clk = ~clk;
   cpu_bus_model i_cpu_bus_model (.clk(clk), .rdata(rdat), .rvalid(rv),
      .addr(addr), .wr(wr), .rd(rd), .be(be), .wdata(wd));
   timer_core i_timer_core (.SYS_CLK(clk), .RST(rst), .STANDBY(sb),
      .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd), .BUS_BE(be),
      .BUS_WDATA(wd), .BUS_RDATA(rdat), .BUS_RVALID(rv), .EXT_CLK_IN(4'h0),
      .PIN_A_IN(pin), .PIN_B_IN(5'h00), .PIN_A_OUT(pa), .PIN_A_OE_N(),
      .PIN_B_OUT(pb), .PIN_B_OE_N(), .ALT_OUT(alt), .ALT_OE_N());
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic w(input logic [7:0] a, input logic [15:0] d);
      i_cpu_bus_model.wr16(a, 2'h3, d);
   endtask
   // masked read compare
   task automatic rchk(input logic [7:0] a, input logic [15:0] m, e);
      logic [15:0] d;
      logic        ok;
      i_cpu_bus_model.rd16(a, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d & m, e)
   endtask
   // rising edge on channel 1 pin A, then time for the synchroniser
   task automatic edge1;
      @(posedge clk);
      pin[1] <= 1'b0;
      cyc(6);
      pin[1] <= 1'b1;
      cyc(8);
   endtask
   task automatic t_init;
      rchk(8'h08, 16'hFFFF, 16'h00FF);
      rchk(8'h06, 16'hFFFF, 16'h00FF);
      rchk(8'h46, 16'hFFFF, 16'h0000);
      rchk(8'h58, 16'hFFFF, 16'hFFFF);
      rchk(8'h0E, 16'hFFFF, 16'h0000);
      w(8'h08, 16'h0000);
      rchk(8'h08, 16'hFFFF, 16'h00EC);
      w(8'h16, 16'hFFFE);
      i_cpu_bus_model.wr16(8'h16, 2'h2, 16'h1200);
      rchk(8'h16, 16'hFFFF, 16'h12FE);
      i_cpu_bus_model.wr16(8'h3A, 2'h1, 16'h0034);
      rchk(8'h3A, 16'hFFFF, 16'hFF34);
      $display("test init done");
   endtask
   task automatic t_count;
      logic [15:0] d;
      logic        ok;
      w(8'h16, 16'hFFFE);
      w(8'h00, 16'h0001);
      cyc(4);
      w(8'h00, 16'h0000);
      rchk(8'h14, 16'h0007, 16'h0007);
      w(8'h28, 16'h0005);
      w(8'h20, 16'h0020);
      w(8'h00, 16'h0002);
      cyc(20);
      w(8'h00, 16'h0000);
      i_cpu_bus_model.rd16(8'h26, d, ok);
      `CHK(d <= 16'h0005, 1'b1)
      rchk(8'h24, 16'h0001, 16'h0001);
      $display("test count done");
   endtask
   task automatic t_trig;
      w(8'h08, 16'h0003);
      w(8'h22, 16'h0004);
      edge1();
      rchk(8'h06, 16'hFFFF, 16'h00FF);
      w(8'h04, 16'h0002);
      edge1();
      rchk(8'h06, 16'hFFFF, 16'h00C0);
      `CHK({pa[3], pb[3], alt}, 4'h7)
      w(8'h06, 16'h00FF);
      w(8'h08, 16'h00FF);
      edge1();
      rchk(8'h06, 16'hFFFF, 16'h00FF);
      $display("test trigger done");
   endtask
   task automatic t_standby;
      logic [7:0]  a[3] = '{8'h08, 8'h16, 8'h18};
      logic [15:0] e[3] = '{16'h00FF, 16'h0000, 16'hFFFF};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         sb <= 1'b1;
         @(posedge clk);
         sb <= 1'b0;
         rchk(a[i], 16'hFFFF, e[i]);
      end
      $display("test standby done");
   endtask
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the roughly 170 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         $display("ERROR %0t timeout", $time);
         end_sim();
      end
   end
   initial begin
      cyc(12);
      rst <= 1'b0;
      t_init();
      t_count();
      t_trig();
      t_standby();
      end_sim();
   end
endmodule
